/* src/rpf_framer.sv */
// Purpose: Frames channel data words into recorder packets.
// Assumes: Source gives the content length up front; one clock.
// Notes: Output words are little-endian 32-bit words.
// Overview of operation
// - Trailer carries an 8, 16 or 32 bit checksum, or none.
// - 16-bit checksum: filler first, then bytes least significant first.
// - 8-bit checksum: filler bytes then one checksum byte.
// - Packets stay at or below 524,288 bytes.
// - Setup record packets may reach 134,217,728 bytes.
// - Oversized content splits over consecutive packets with sequence counts.
// - Setup record packets come first in every recording.
// - A time packet is the first packet after setup records.
// - Other data follows the first time packet, before root index.
// - With indexing on, the root index packet ends the recording.
// - Non-computer packets close within 100 ms when data is available.
// - A packet holds at most 100 ms from its first data.
// - No empty or filler-only packets are ever emitted.
// - Reserved header and data word bits are zero.
// - Non-computer packets commit to the stream within 1,000 ms.
// - Version and structure bits per channel never change mid-recording.
// - Secondary header: time low word, high word, reserved plus checksum.
// - Header is 24 bytes, ten fields contiguous.
// - Each packet starts with the fixed sync value.
// - Packet length in bytes, always a multiple of four.
// - Data length counts body bytes, not filler or checksum.
`timescale 1ns/100ps
`include "rpf_params.svh"

// ----------------------------------------------------------------
// Data FIFO
// ----------------------------------------------------------------
module rpf_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	input wire logic clk, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic s_valid, // Write word offered.
	output logic s_ready, // Room for a word.
	input wire logic [W-1:0] s_data, // Write word.
	output logic m_valid, // Read word present.
	input wire logic m_ready, // Read word taken.
	output logic [W-1:0] m_data // Read word.
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_q, wp_d, rp_q, rp_d;
	logic full, empty;

	// Pointers carry one wrap bit to tell full from empty; D is a power of two.
	always_comb begin
		full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
		empty = (wp_q == rp_q);
		wp_d = wp_q + (AW+1)'(s_valid && !full);
		rp_d = rp_q + (AW+1)'(m_ready && !empty);
	end

	assign s_ready = !full;
	assign m_valid = !empty;
	assign m_data = mem[rp_q[AW-1:0]];

	// Pointer registers.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	// Storage needs no reset.
	always_ff @(posedge clk) begin
		if (s_valid && !full) begin
			mem[wp_q[AW-1:0]] <= s_data;
		end
	end
endmodule

// ----------------------------------------------------------------
// Packet framer
// ----------------------------------------------------------------
module rpf_framer #(
	parameter int SLOTS = 16,
	parameter int FIFO_DEPTH = 16,
	parameter int GEN_CYC = `RPF_GEN_CYC,
	parameter int COMMIT_CYC = `RPF_COMMIT_CYC
) (
	input wire logic clk, // System clock, 20 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic rec_start, // Pulse: a new recording begins.
	input wire logic index_en, // Recording index packets enabled.
	input wire logic req_valid, // Packet request offered.
	output logic req_ready, // Request taken this cycle.
	output logic req_refused, // Request out of order or empty.
	input wire logic [15:0] req_channel, // Channel number.
	input wire logic [7:0] req_type, // Data type.
	input wire logic [7:0] req_version, // Data type version.
	input wire logic req_sec_en, // Secondary header wanted.
	input wire logic req_intra_packet_stamp_src, // Intra-packet stamp source flag.
	input wire logic [1:0] req_time_fmt, // Secondary time format.
	input wire logic [1:0] req_csum, // Checksum mode.
	input wire logic [63:0] req_sec_time, // Secondary header time.
	input wire logic [25:0] req_words, // Content length in words.
	input wire logic in_valid, // Content word offered.
	output logic in_ready, // FIFO has room.
	input wire logic [31:0] in_data, // Content word.
	output logic out_valid, // Packet word present.
	input wire logic out_ready, // Packet word taken.
	output logic [31:0] out_data, // Packet word.
	output logic out_sop, // First word of a packet.
	output logic out_eop, // Last word of a packet.
	output logic gen_late, // Pulse: packet body not done in time.
	output logic commit_late // Pulse: packet not committed in time.
);
	localparam int SW = $clog2(SLOTS);
	localparam logic [25:0] MAXW = 26'(`RPF_BODY_MAX_W);
	localparam logic [25:0] MAXW_SETUP = 26'(`RPF_SETUP_MAX_W);

	rpf_pkg::rpf_state_t st_q, st_d;
	rpf_pkg::rpf_phase_t ph_q, ph_d;
	rpf_pkg::rpf_csum_t mode;
	logic [3:0] idx_q, idx_d;
	logic [25:0] rem_q, rem_d, cnt_q, cnt_d, pktw_q, pktw_d, rsrc;
	logic [15:0] ch_q, ch_d;
	logic [7:0] ty_q, ty_d, ver_q, ver_d, flg_q, flg_d;
	logic [63:0] stime_q, stime_d;
	logic [31:0] acc_q, acc_d, od_q, od_d;
	logic [47:0] ts_q, ts_d, rtc_q, rtc_d;
	logic ov_q, ov_d, osop_q, osop_d, oeop_q, oeop_d;
	logic [7:0] seq_q [SLOTS];
	logic [7:0] seq_d [SLOTS];
	logic [7:0] lver_q [SLOTS];
	logic [7:0] lver_d [SLOTS];
	logic [7:0] lflg_q [SLOTS];
	logic [7:0] lflg_d [SLOTS];
	logic [SLOTS-1:0] lock_q, lock_d;
	logic div_q, div_d, aging_q, aging_d, gl_q, gl_d, cl_q, cl_d;
	logic [31:0] age_q, age_d;
	logic f_valid, f_ready, adv, sec, last_hdr, start, finish, req_ok;
	logic [31:0] f_data, plen, dlen, hw0, hw3, hw4, hw5, hword, tword;
	logic [15:0] hcs, scs;
	logic [SW-1:0] slot, rs;

	function automatic logic [15:0] fold16(input logic [31:0] w);
		return w[31:16] + w[15:0];
	endfunction

	function automatic logic is_grp(input logic [7:0] t, input logic [4:0] g);
		return t[7:3] == g;
	endfunction

	// Words of this packet: the rest, or the most that fits the size limit.
	function automatic logic [25:0] chunk(input logic [25:0] r, input logic [7:0] t);
		logic [25:0] m;
		m = (t == `RPF_TYPE_SETUP) ? MAXW_SETUP : MAXW;
		return (r > m) ? m : r;
	endfunction

	// Running data checksum at the width of the mode.
	function automatic logic [31:0] csum_add(input rpf_pkg::rpf_csum_t m,
			input logic [31:0] a, input logic [31:0] w);
		logic [7:0] b;
		b = a[7:0] + w[7:0] + w[15:8] + w[23:16] + w[31:24];
		case (m)
			rpf_pkg::CSUM_8: return {24'h000000, b};
			rpf_pkg::CSUM_16: return {16'h0000, a[15:0] + fold16(w)};
			default: return a + w;
		endcase
	endfunction

	rpf_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.s_valid(in_valid),
		.s_ready(in_ready),
		.s_data(in_data),
		.m_valid(f_valid),
		.m_ready(f_ready),
		.m_data(f_data)
	);

	// Header, secondary header and trailer words of the current packet.
	always_comb begin
		mode = rpf_pkg::rpf_csum_t'(flg_q[1:0]);
		sec = flg_q[`RPF_FLAG_SEC];
		slot = ch_q[SW-1:0];
		dlen = {4'h0, pktw_q, 2'b00};
		plen = `RPF_HDR_BYTES + (sec ? `RPF_SEC_BYTES : 32'h0) + dlen
			+ ((mode != rpf_pkg::CSUM_NONE) ? `RPF_TRL_BYTES : 32'h0);
		hw0 = {ch_q, `RPF_SYNC};
		hw3 = {ty_q, flg_q, seq_q[slot], ver_q};
		hw4 = ts_q[31:0];
		hcs = fold16(hw0) + fold16(plen) + fold16(dlen) + fold16(hw3) + fold16(hw4)
			+ ts_q[47:32];
		hw5 = {hcs, ts_q[47:32]};
		scs = fold16(stime_q[31:0]) + fold16(stime_q[63:32]);
		case (idx_q)
			4'h0: hword = hw0;
			4'h1: hword = plen;
			4'h2: hword = dlen;
			4'h3: hword = hw3;
			4'h4: hword = hw4;
			4'h5: hword = hw5;
			4'h6: hword = stime_q[31:0];
			4'h7: hword = stime_q[63:32];
			default: hword = {scs, 16'h0000};
		endcase
		last_hdr = (idx_q == (sec ? `RPF_SEC_LAST : `RPF_HDR_LAST));
		case (mode)
			rpf_pkg::CSUM_8: tword = {acc_q[7:0], 24'h000000};
			rpf_pkg::CSUM_16: tword = {acc_q[15:0], 16'h0000};
			default: tword = acc_q;
		endcase
	end

	// Order of packet types in a recording.
	always_comb begin
		case (ph_q)
			rpf_pkg::PH_SETUP: req_ok = (req_type == `RPF_TYPE_SETUP);
			rpf_pkg::PH_TIME: req_ok = (req_type == `RPF_TYPE_SETUP)
				|| is_grp(req_type, `RPF_GRP_TIME);
			rpf_pkg::PH_DATA: req_ok = (req_type != `RPF_TYPE_SETUP);
			default: req_ok = 1'b0;
		endcase
		req_ok = req_ok && (req_words != 26'h0);
		req_ready = (st_q == rpf_pkg::ST_IDLE) && req_ok && !rec_start;
		req_refused = (st_q == rpf_pkg::ST_IDLE) && req_valid && !req_ok;
		rs = req_channel[SW-1:0];
	end

	assign adv = !ov_q || out_ready;
	assign f_ready = (st_q == rpf_pkg::ST_BODY) && adv;

	// Framing sequence: next values.
	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		idx_d = idx_q;
		rem_d = rem_q;
		cnt_d = cnt_q;
		pktw_d = pktw_q;
		ch_d = ch_q;
		ty_d = ty_q;
		ver_d = ver_q;
		flg_d = flg_q;
		stime_d = stime_q;
		acc_d = acc_q;
		ts_d = ts_q;
		seq_d = seq_q;
		lver_d = lver_q;
		lflg_d = lflg_q;
		lock_d = lock_q;
		ov_d = ov_q && !out_ready;
		od_d = od_q;
		osop_d = osop_q;
		oeop_d = oeop_q;
		start = 1'b0;
		finish = 1'b0;
		rsrc = rem_q;
		case (st_q)
			rpf_pkg::ST_IDLE: begin
				if (req_valid && req_ready) begin
					start = 1'b1;
					rsrc = req_words;
					ch_d = req_channel;
					ty_d = req_type;
					stime_d = req_sec_time;
					if (lock_q[rs]) begin
						ver_d = lver_q[rs];
						flg_d = lflg_q[rs];
					end else begin
						ver_d = req_version;
						flg_d = {req_sec_en, req_intra_packet_stamp_src, 2'b00, req_time_fmt, req_csum};
						lock_d[rs] = 1'b1;
						lver_d[rs] = req_version;
						lflg_d[rs] = flg_d;
					end
					if (ph_q == rpf_pkg::PH_SETUP) begin
						ph_d = rpf_pkg::PH_TIME;
					end else if (ph_q == rpf_pkg::PH_TIME && req_type != `RPF_TYPE_SETUP) begin
						ph_d = rpf_pkg::PH_DATA;
					end else if (index_en && req_type == `RPF_TYPE_INDEX) begin
						ph_d = rpf_pkg::PH_DONE;
					end
				end
			end
			rpf_pkg::ST_HDR: begin
				if (adv) begin
					ov_d = 1'b1;
					od_d = hword;
					osop_d = (idx_q == 4'h0);
					oeop_d = 1'b0;
					idx_d = idx_q + 4'h1;
					if (last_hdr) begin
						st_d = rpf_pkg::ST_BODY;
						acc_d = 32'h00000000;
					end
				end
			end
			rpf_pkg::ST_BODY: begin
				if (adv && f_valid) begin
					ov_d = 1'b1;
					od_d = f_data;
					osop_d = 1'b0;
					oeop_d = (cnt_q == 26'h1) && (mode == rpf_pkg::CSUM_NONE);
					acc_d = csum_add(mode, acc_q, f_data);
					cnt_d = cnt_q - 26'h1;
					if (cnt_q == 26'h1) begin
						finish = (mode == rpf_pkg::CSUM_NONE);
						st_d = rpf_pkg::ST_TRAIL;
					end
				end
			end
			rpf_pkg::ST_TRAIL: begin
				if (adv) begin
					ov_d = 1'b1;
					od_d = tword;
					osop_d = 1'b0;
					oeop_d = 1'b1;
					finish = 1'b1;
				end
			end
			default: st_d = rpf_pkg::ST_IDLE;
		endcase
		if (finish) begin
			seq_d[slot] = seq_q[slot] + 8'h01;
			st_d = rpf_pkg::ST_IDLE;
			start = (rem_q != 26'h0);
		end
		if (start) begin
			pktw_d = chunk(rsrc, ty_d);
			cnt_d = pktw_d;
			rem_d = rsrc - pktw_d;
			ts_d = rtc_q;
			idx_d = 4'h0;
			st_d = rpf_pkg::ST_HDR;
		end
		if (rec_start) begin
			ph_d = rpf_pkg::PH_SETUP;
			lock_d = '0;
			seq_d = '{default: 8'h00};
		end
	end

	// Time base and latency watchdog: next values.
	always_comb begin
		div_d = !div_q;
		rtc_d = rtc_q + (div_q ? 48'h000000000001 : 48'h000000000000);
		age_d = age_q + (aging_q ? 32'h00000001 : 32'h00000000);
		aging_d = aging_q && !(ov_q && out_ready && oeop_q);
		// Late only while header or body words are still pending, not while eop waits.
		gl_d = aging_q && (age_q == 32'(GEN_CYC))
			&& (st_q == rpf_pkg::ST_HDR || st_q == rpf_pkg::ST_BODY);
		cl_d = aging_q && aging_d && (age_q == 32'(COMMIT_CYC));
		if (start) begin
			age_d = 32'h00000000;
			aging_d = !is_grp(ty_d, `RPF_GRP_CG);
		end
	end

	// State registers.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= rpf_pkg::ST_IDLE;
			ph_q <= rpf_pkg::PH_SETUP;
			idx_q <= 4'h0;
			rem_q <= 26'h0;
			cnt_q <= 26'h0;
			pktw_q <= 26'h0;
			ch_q <= 16'h0000;
			ty_q <= 8'h00;
			ver_q <= 8'h00;
			flg_q <= 8'h00;
			stime_q <= 64'h0;
			acc_q <= 32'h0;
			ts_q <= 48'h0;
			seq_q <= '{default: 8'h00};
			lver_q <= '{default: 8'h00};
			lflg_q <= '{default: 8'h00};
			lock_q <= '0;
			ov_q <= 1'b0;
			od_q <= 32'h0;
			osop_q <= 1'b0;
			oeop_q <= 1'b0;
			div_q <= 1'b0;
			rtc_q <= 48'h0;
			age_q <= 32'h0;
			aging_q <= 1'b0;
			gl_q <= 1'b0;
			cl_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			idx_q <= idx_d;
			rem_q <= rem_d;
			cnt_q <= cnt_d;
			pktw_q <= pktw_d;
			ch_q <= ch_d;
			ty_q <= ty_d;
			ver_q <= ver_d;
			flg_q <= flg_d;
			stime_q <= stime_d;
			acc_q <= acc_d;
			ts_q <= ts_d;
			seq_q <= seq_d;
			lver_q <= lver_d;
			lflg_q <= lflg_d;
			lock_q <= lock_d;
			ov_q <= ov_d;
			od_q <= od_d;
			osop_q <= osop_d;
			oeop_q <= oeop_d;
			div_q <= div_d;
			rtc_q <= rtc_d;
			age_q <= age_d;
			aging_q <= aging_d;
			gl_q <= gl_d;
			cl_q <= cl_d;
		end
	end

	assign out_valid = ov_q;
	assign out_data = od_q;
	assign out_sop = osop_q;
	assign out_eop = oeop_q;
	assign gen_late = gl_q;
	assign commit_late = cl_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sync_first_a: assert property (@(posedge clk) disable iff (!rst_b)
		out_valid && out_sop |-> out_data == {ch_q, 16'hEB25})
		else $error("packet does not open with sync");
	len_align_a: assert property (@(posedge clk) disable iff (!rst_b)
		st_q == rpf_pkg::ST_HDR && idx_q == 4'h1 && adv |=> out_data[1:0] == 2'b00)
		else $error("packet length not word aligned");
	size_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
		st_q != rpf_pkg::ST_IDLE && ty_q != 8'h01 |-> plen <= 32'h80000)
		else $error("packet exceeds size limit");
	setup_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
		st_q != rpf_pkg::ST_IDLE |-> plen <= 32'h8000000)
		else $error("setup packet exceeds size limit");
	no_empty_a: assert property (@(posedge clk) disable iff (!rst_b)
		st_q == rpf_pkg::ST_HDR |-> pktw_q != 26'h0)
		else $error("empty packet started");
	setup_first_a: assert property (@(posedge clk) disable iff (!rst_b)
		req_valid && req_ready && ph_q == rpf_pkg::PH_SETUP |-> req_type == 8'h01)
		else $error("non-setup packet before setup record");
	time_next_a: assert property (@(posedge clk) disable iff (!rst_b)
		req_valid && req_ready && ph_q == rpf_pkg::PH_TIME && req_type != 8'h01
		|-> req_type[7:3] == 5'h02 ##1 ph_q == rpf_pkg::PH_DATA)
		else $error("first dynamic packet is not time data");
	closed_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		ph_q == rpf_pkg::PH_DONE && !rec_start |-> !req_ready)
		else $error("packet accepted after root index");
	trail_byte_a: assert property (@(posedge clk) disable iff (!rst_b)
		st_q == rpf_pkg::ST_TRAIL && adv && mode == rpf_pkg::CSUM_8
		|=> out_eop && out_data == {$past(acc_q[7:0]), 24'h000000})
		else $error("8-bit trailer malformed");
	seq_step_a: assert property (@(posedge clk) disable iff (!rst_b)
		finish && !rec_start |=> seq_q[$past(slot)] == $past(seq_q[slot]) + 8'h01)
		else $error("sequence counter did not step");
endmodule

/* src/rpf_params.svh */
// Purpose: Constants of the recording packet framer.
// Assumes: 20 MHz system clock, 10 MHz relative time counter.
// Notes: Byte counts are 32 bits wide, words are 32 bits.
`ifndef RPF_PARAMS_SVH
`define RPF_PARAMS_SVH

// ----------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------
`define RPF_SYNC 16'hEB25
`define RPF_HDR_BYTES 32'h18
`define RPF_SEC_BYTES 32'hC
`define RPF_TRL_BYTES 32'h4
`define RPF_MAX_BYTES 32'h80000
`define RPF_MAX_SETUP_BYTES 32'h8000000
`define RPF_BODY_MAX_W ((`RPF_MAX_BYTES-`RPF_HDR_BYTES-`RPF_SEC_BYTES-`RPF_TRL_BYTES)>>2)
`define RPF_SETUP_MAX_W ((`RPF_MAX_SETUP_BYTES-`RPF_HDR_BYTES-`RPF_SEC_BYTES-`RPF_TRL_BYTES)>>2)
`define RPF_HDR_LAST 4'h5
`define RPF_SEC_LAST 4'h8

// ----------------------------------------------------------------
// Data types and flag bits
// ----------------------------------------------------------------
`define RPF_TYPE_SETUP 8'h01
`define RPF_TYPE_INDEX 8'h03
`define RPF_GRP_CG 5'h00
`define RPF_GRP_TIME 5'h02
`define RPF_FLAG_SEC 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPF_CLK_NS 32'h32
`define RPF_GEN_MS 32'h64
`define RPF_COMMIT_MS 32'h3E8
`define RPF_NS_PER_MS 32'hF4240
`define RPF_GEN_CYC (`RPF_GEN_MS * `RPF_NS_PER_MS / `RPF_CLK_NS)
`define RPF_COMMIT_CYC (`RPF_COMMIT_MS * `RPF_NS_PER_MS / `RPF_CLK_NS)

`endif

/* src/rpf_pkg.sv */
// Purpose: Types of the recording packet framer.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Checksum mode order matches the two flag bits.
package rpf_pkg;
	typedef enum logic [1:0] {CSUM_NONE, CSUM_8, CSUM_16, CSUM_32} rpf_csum_t;
	typedef enum logic [1:0] {PH_SETUP, PH_TIME, PH_DATA, PH_DONE} rpf_phase_t;
	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_BODY, ST_TRAIL} rpf_state_t;
endpackage

/* tb/rpf_framer_bench.sv */
// Purpose: Self-checking bench of the recording packet framer.
// Assumes: Latency limits shortened to 200 and 400 cycles; words of a packet are random.
// Notes: The driver notes every expected packet word; a monitor compares them in order.
`timescale 1ns/100ps

module rpf_framer_bench;
	typedef struct {logic [31:0] d; logic [31:0] m; logic s; logic e;} rpf_exp_t;
	logic clk = 1'b0, rst_b = 1'b0, rec_start = 1'b0, index_en = 1'b0, slow = 1'b0;
	logic req_valid = 1'b0, req_sec_en = 1'b0, req_intra_packet_stamp_src = 1'b0, in_valid = 1'b0;
	logic [15:0] req_channel = 16'h0;
	logic [7:0] req_type = 8'h0, req_version = 8'h0;
	logic [1:0] req_time_fmt = 2'h0, req_csum = 2'h0;
	logic [63:0] req_sec_time = 64'h0;
	logic [25:0] req_words = 26'h0;
	logic [31:0] in_data = 32'h0, out_data;
	logic req_ready, req_refused, in_ready, out_valid, out_ready, out_sop, out_eop;
	logic gen_late, commit_late;
	int fails = 0, cmp_count = 0, n_gen = 0, n_com = 0, hidx = 6;
	logic [15:0] hsum = 16'h0000;
	rpf_exp_t exq[$];
	logic [7:0] seq[16], lv[16], lf[16];
	bit lk[16];

	// ----------------------------------------------------------------
	// Clock, design and consumer
	// ----------------------------------------------------------------
	always #25 clk = ~clk;

	rpf_framer #(.GEN_CYC(200), .COMMIT_CYC(400)) u_rpf_framer (.clk(clk), .rst_b(rst_b),
		.rec_start(rec_start), .index_en(index_en), .req_valid(req_valid),
		.req_ready(req_ready), .req_refused(req_refused), .req_channel(req_channel),
		.req_type(req_type), .req_version(req_version), .req_sec_en(req_sec_en),
		.req_intra_packet_stamp_src(req_intra_packet_stamp_src), .req_time_fmt(req_time_fmt), .req_csum(req_csum),
		.req_sec_time(req_sec_time), .req_words(req_words), .in_valid(in_valid),
		.in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .gen_late(gen_late),
		.commit_late(commit_late));

	rpf_sink u_rpf_sink (.clk(clk), .rst_b(rst_b), .slow(slow), .out_ready(out_ready));

	// ----------------------------------------------------------------
	// Checking and reporting
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic print_verdict;
		$display("counts: %0d comparisons, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Each taken packet word is compared with the oldest noted one.
	always @(posedge clk) begin
		if (rst_b && out_valid === 1'b1 && out_ready === 1'b1) begin
			// Header checksum: halfwords of words 0 to 4 plus the low half of word 5.
			hidx = (out_sop === 1'b1) ? 0 : hidx + 1;
			if (hidx == 0) hsum = 16'h0000;
			if (hidx < 5) hsum += out_data[31:16] + out_data[15:0];
			if (hidx == 5) chk("header checksum", {16'h0, 16'(hsum + out_data[15:0])},
				{16'h0, out_data[31:16]});
			if (exq.size() == 0) begin
				chk("surplus word", 32'h0, 32'h1);
			end else begin
				chk("out_data", exq[0].d & exq[0].m, out_data & exq[0].m);
				chk("out_sop", {31'h0, exq[0].s}, {31'h0, out_sop});
				chk("out_eop", {31'h0, exq[0].e}, {31'h0, out_eop});
				void'(exq.pop_front());
			end
		end
		n_gen += (gen_late === 1'b1);
		n_com += (commit_late === 1'b1);
	end

	// ----------------------------------------------------------------
	// Driver tasks
	// ----------------------------------------------------------------
	task automatic note(input logic [31:0] d, input logic [31:0] m, input logic s, input logic e);
		exq.push_back('{d, m, s, e});
	endtask

	task automatic feed(input logic [31:0] w[$]);
		int k;
		foreach (w[i]) begin
			@(negedge clk);
			in_valid = 1'b1;
			in_data = w[i];
			#1;
			for (k = 0; k < 2000 && in_ready !== 1'b1; k++) @(negedge clk);
			@(posedge clk);
		end
		@(negedge clk);
		in_valid = 1'b0;
	endtask

	task automatic refuse(input logic [7:0] ty, input int n);
		@(negedge clk);
		req_valid = 1'b1;
		req_type = ty;
		req_words = n[25:0];
		#1;
		chk("req_refused", 32'h1, {31'h0, req_refused});
		chk("req_ready", 32'h0, {31'h0, req_ready});
		@(negedge clk);
		req_valid = 1'b0;
	endtask

	task automatic frame(input logic [15:0] ch, input logic [7:0] ty, input logic [7:0] ver,
			input logic sec, input logic ips, input logic [1:0] cs, input int n, input int dly,
			input bit pre);
		logic [31:0] w[$];
		logic [31:0] x, s32;
		logic [15:0] s16, ts;
		logic [7:0] s8, fl;
		logic [63:0] tm;
		logic [1:0] fmt;
		int k;
		s32 = 32'h0;
		s16 = 16'h0;
		s8 = 8'h0;
		tm = {$urandom, $urandom};
		fmt = 2'($urandom);
		for (k = 0; k < n; k++) begin
			x = $urandom;
			w.push_back(x);
			s32 += x;
			s16 += x[15:0] + x[31:16];
			s8 += x[7:0] + x[15:8] + x[23:16] + x[31:24];
		end
		if (!lk[ch[3:0]]) begin
			lk[ch[3:0]] = 1'b1;
			lv[ch[3:0]] = ver;
			lf[ch[3:0]] = {sec, ips, 2'h0, fmt, cs};
		end
		fl = lf[ch[3:0]];
		ts = tm[15:0] + tm[31:16] + tm[47:32] + tm[63:48];
		note({ch, 16'hEB25}, 32'hFFFFFFFF, 1'b1, 1'b0);
		note(32'd24 + (fl[7] ? 32'd12 : 32'd0) + n * 4 + (fl[1:0] != 2'h0 ? 32'd4 : 32'd0),
			32'hFFFFFFFF, 1'b0, 1'b0);
		note(n * 4, 32'hFFFFFFFF, 1'b0, 1'b0);
		note({ty, fl, seq[ch[3:0]], lv[ch[3:0]]}, 32'hFFFFFFFF, 1'b0, 1'b0);
		note(32'h0, 32'h0, 1'b0, 1'b0);
		note(32'h0, 32'h0000FFFF, 1'b0, 1'b0);
		seq[ch[3:0]]++;
		if (fl[7]) begin
			note(tm[31:0], 32'hFFFFFFFF, 1'b0, 1'b0);
			note(tm[63:32], 32'hFFFFFFFF, 1'b0, 1'b0);
			note({ts, 16'h0}, 32'hFFFFFFFF, 1'b0, 1'b0);
		end
		foreach (w[i]) note(w[i], 32'hFFFFFFFF, 1'b0, i == n - 1 && fl[1:0] == 2'h0);
		case (fl[1:0])
			2'h1: note({s8, 24'h0}, 32'hFFFFFFFF, 1'b0, 1'b1);
			2'h2: note({s16, 16'h0}, 32'hFFFFFFFF, 1'b0, 1'b1);
			2'h3: note(s32, 32'hFFFFFFFF, 1'b0, 1'b1);
			default: ;
		endcase
		if (pre) begin
			feed(w);
			#1;
			chk("in_ready full", 32'h0, {31'h0, in_ready});
		end
		@(negedge clk);
		{req_channel, req_type, req_version, req_sec_en, req_intra_packet_stamp_src} = {ch, ty, ver, sec, ips};
		{req_time_fmt, req_csum, req_sec_time, req_words} = {fmt, cs, tm, n[25:0]};
		req_valid = 1'b1;
		fork
			begin
				#1;
				for (k = 0; k < 2000 && req_ready !== 1'b1; k++) @(negedge clk) #1;
				chk("req_ready", 32'h1, {31'h0, req_ready});
				@(negedge clk);
				req_valid = 1'b0;
			end
			begin
				repeat (dly) @(negedge clk);
				if (!pre) feed(w);
			end
		join
		for (k = 0; k < 5000 && exq.size() > 0; k++) @(posedge clk);
		chk("words left", 32'h0, exq.size());
		repeat (3) @(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	// Main sequence: order, every checksum mode, version lock, latency and closing index.
	initial begin
		void'($urandom(71057));
		foreach (seq[i]) begin
			seq[i] = 8'h0;
			lk[i] = 1'b0;
		end
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		rec_start = 1'b1;
		@(negedge clk);
		rec_start = 1'b0;
		refuse(8'h11, 4);
		refuse(8'h01, 0);
		$display("test order done");
		frame(16'h0, 8'h01, 8'h06, 1'b0, 1'b0, 2'h0, $urandom_range(1, 24), 0, 0);
		frame(16'h0, 8'h01, 8'h06, 1'b0, 1'b0, 2'h0, 3, 0, 0);
		frame(16'h1, 8'h11, 8'h03, 1'b1, 1'b0, 2'h1, $urandom_range(1, 24), 0, 0);
		refuse(8'h01, 4);
		slow = 1'b1;
		frame(16'h2, 8'h19, 8'h03, 1'b0, 1'b0, 2'h2, $urandom_range(1, 24), 0, 0);
		frame(16'h3, 8'h21, 8'h02, 1'b1, 1'b1, 2'h3, $urandom_range(1, 24), 0, 0);
		frame(16'h4, 8'h29, 8'h02, 1'b0, 1'b0, 2'h0, 16, 0, 1);
		$display("test checksum modes done");
		frame(16'h2, 8'h19, 8'h09, 1'b0, 1'b1, 2'h2, 5, 0, 0);
		$display("test version lock done");
		chk("gen_late count", 32'h0, n_gen);
		slow = 1'b0;
		frame(16'h5, 8'h21, 8'h02, 1'b0, 1'b0, 2'h1, 2, 450, 0);
		chk("gen_late count", 32'h1, n_gen);
		chk("commit_late count", 32'h1, n_com);
		$display("test latency done");
		index_en = 1'b1;
		frame(16'h6, 8'h03, 8'h03, 1'b0, 1'b0, 2'h0, 2, 0, 0);
		refuse(8'h19, 4);
		$display("test index close done");
		print_verdict;
	end

	// Watchdog sized well above the run of all tests.
	initial begin
		#(50 * 60000);
		fails++;
		print_verdict;
	end
endmodule

/* tb/rpf_sink.sv */
// Purpose: Stream consumer model standing at the output of the packet framer.
// Assumes: Packet words are taken on rising clk edges when valid and ready are both high.
// Notes: In slow mode ready is withdrawn at random to stall the framer and its FIFO.
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Consumer
// ----------------------------------------------------------------
module rpf_sink (
	input wire logic clk, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic slow, // Stall at random when high.
	output logic out_ready // Packet word taken.
);
	// Ready moves only at the falling edge, so it is settled at the sampling edge.
	always @(negedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= !slow || ($urandom_range(0, 1) == 1);
		end
	end
endmodule
